// ---- rtl/rsf_defines.svh ----
// Register offsets, reset values, limits and timing counts of the suppression filter
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH

// ****************************************************************
// Parameter addresses
// ****************************************************************
`define RSF_ADDR_N1_FREQ   16'h022E
`define RSF_ADDR_N1_ATT    16'h0230
`define RSF_ADDR_LP_TC     16'h0232
`define RSF_ADDR_N2_FREQ   16'h0256
`define RSF_ADDR_N2_ATT    16'h0258
`define RSF_ADDR_N3_FREQ   16'h025A
`define RSF_ADDR_N3_ATT    16'h025C
`define RSF_ADDR_AUTO      16'h025E

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define RSF_FREQ_RST       16'h03E8
`define RSF_ATT_RST        16'h0000
`define RSF_LP_TC_RST_LOW  16'h0002
`define RSF_LP_TC_RST_HIGH 16'h0005
`define RSF_ATT_MAX        16'h0020
`define RSF_LP_TC_MAX      16'h03E8
`define RSF_FREQ_MIN       16'h0032
`define RSF_FREQ_MAX       16'h07D0
`define RSF_N1_FREQ_MAX    16'h03E8

// ****************************************************************
// Timing
// ****************************************************************
`define RSF_CLK_HZ         64'h0000_0000_0EE6_B280
`define RSF_STABLE_MIN     64'h0000_0000_0000_0014
`define RSF_STABLE_CYCLES  (`RSF_STABLE_MIN * 64'h0000_0000_0000_003C * `RSF_CLK_HZ)
`define RSF_STRAP_WAIT     2'h3

// ****************************************************************
// Filter coefficients (Q14 unless noted)
// ****************************************************************
`define RSF_NOTCH_A2       18'h0_3CCD
`define RSF_NOTCH_H        18'h0_3E66
`define RSF_W2_MUL         48'h0000_0000_0A59
`define RSF_TS_Q4          32'h0000_000A
`define RSF_ONE_Q15        32'h0000_8000
`define RSF_TWO_Q14        18'h0_8000

`endif

// ---- rtl/rsf_lowpass.sv ----
// First-order low-pass stage of the resonance suppression chain
`timescale 1ns/1ns
`include "rsf_defines.svh"
module rsf_lowpass
    import rsf_pkg::*;
(
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [15:0]  tc_i,
    input  rsf_sample_t       in_i,
    output rsf_sample_t       out_o
);

    logic        [15:0] alpha_reg;
    logic        [15:0] alpha_next;
    logic signed [15:0] y_reg;
    logic signed [15:0] y_next;
    rsf_sample_t        out_reg;
    rsf_sample_t        out_next;
    logic        [31:0] alpha_full;
    logic signed [47:0] step;

    // ****************************************************************
    // Coefficient and state update
    // ****************************************************************
    always_comb
    begin
        // Larger time constant gives smaller alpha, lower cutoff
        alpha_full = (`RSF_ONE_Q15 * `RSF_TS_Q4) / (`RSF_TS_Q4 + {12'h000, tc_i, 4'h0});
        alpha_next = alpha_full[15:0];
        y_next     = y_reg;
        out_next   = out_reg;
        step       = (48'($signed({1'b0, alpha_reg})) *
                      (48'(in_i.data) - 48'(y_reg))) >>> 15;
        out_next.valid = in_i.valid;
        if (in_i.valid)
        begin
            if (tc_i == 16'h0000)
            begin
                // Pass straight through, keep state aligned
                y_next        = in_i.data;
                out_next.data = in_i.data;
            end
            else
            begin
                y_next        = rsf_sat16(48'(y_reg) + step);
                out_next.data = rsf_sat16(48'(y_reg) + step);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            alpha_reg <= 16'h0000;
            y_reg     <= 16'sh0000;
            out_reg   <= '0;
        end
        else if (ce_i)
        begin
            alpha_reg <= alpha_next;
            y_reg     <= y_next;
            out_reg   <= out_next;
        end
    end

    assign out_o = out_reg;

endmodule // rsf_lowpass

// ---- rtl/rsf_notch.sv ----
// Second-order notch with programmable centre and depth
`timescale 1ns/1ns
`include "rsf_defines.svh"
module rsf_notch
    import rsf_pkg::*;
(
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic         en_i,
    input  rsf_notch_cfg_t    cfg_i,
    input  rsf_sample_t       in_i,
    output rsf_sample_t       out_o
);

    logic signed [17:0] a1_reg;
    logic signed [17:0] a1_next;
    logic        [15:0] gain_reg;
    logic        [15:0] gain_next;
    logic signed [15:0] x1_reg, x2_reg, y1_reg, y2_reg;
    logic signed [15:0] x1_next, x2_next, y1_next, y2_next;
    rsf_sample_t        out_reg;
    rsf_sample_t        out_next;
    logic        [47:0] w2;
    logic        [17:0] c2;
    logic        [35:0] a1_full;
    logic signed [47:0] acc;
    logic signed [15:0] notch_y;
    logic signed [47:0] mix;

    // Depth in dB to linear centre gain (Q15), 6 dB per halving
    function automatic logic [15:0] depth_gain(input logic [15:0] db);
        logic [15:0] base;
        logic [15:0] rem;
        logic [15:0] oct;
        rem = db % 16'h0006;
        oct = db / 16'h0006;
        case (rem[2:0])
            3'h0:    base = 16'h7FFF;
            3'h1:    base = 16'h7215;
            3'h2:    base = 16'h65AD;
            3'h3:    base = 16'h5A9E;
            3'h4:    base = 16'h50C3;
            default: base = 16'h47FB;
        endcase
        depth_gain = base >> oct[3:0];
    endfunction

    // ****************************************************************
    // Coefficients, recomputed from the live settings
    // ****************************************************************
    always_comb
    begin
        w2        = (48'(cfg_i.freq) * 48'(cfg_i.freq) * `RSF_W2_MUL) >> 20;
        c2        = `RSF_TWO_Q14 - w2[17:0];
        a1_full   = 36'(`RSF_NOTCH_H) * 36'(c2);
        a1_next   = $signed(a1_full[31:14]);
        gain_next = depth_gain(cfg_i.atten);
    end

    // ****************************************************************
    // Sample path
    // ****************************************************************
    always_comb
    begin
        x1_next  = x1_reg;
        x2_next  = x2_reg;
        y1_next  = y1_reg;
        y2_next  = y2_reg;
        out_next = out_reg;
        acc      = 48'($signed(`RSF_NOTCH_H)) * (48'(in_i.data) + 48'(x2_reg))
                 - 48'(a1_reg) * (48'(x1_reg) - 48'(y1_reg))
                 - 48'($signed(`RSF_NOTCH_A2)) * 48'(y2_reg);
        notch_y  = rsf_sat16(acc >>> 14);
        mix      = (48'($signed({1'b0, gain_reg})) * 48'(in_i.data)
                 + (48'($signed(`RSF_ONE_Q15)) - 48'($signed({1'b0, gain_reg})))
                 * 48'(notch_y)) >>> 15;
        out_next.valid = in_i.valid;
        if (in_i.valid)
        begin
            x1_next = in_i.data;
            x2_next = x1_reg;
            y1_next = notch_y;
            y2_next = y1_reg;
            out_next.data = en_i ? rsf_sat16(mix) : in_i.data;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            a1_reg   <= 18'sh0_0000;
            gain_reg <= 16'h7FFF;
            x1_reg   <= 16'sh0000;
            x2_reg   <= 16'sh0000;
            y1_reg   <= 16'sh0000;
            y2_reg   <= 16'sh0000;
            out_reg  <= '0;
        end
        else if (ce_i)
        begin
            a1_reg   <= a1_next;
            gain_reg <= gain_next;
            x1_reg   <= x1_next;
            x2_reg   <= x2_next;
            y1_reg   <= y1_next;
            y2_reg   <= y2_next;
            out_reg  <= out_next;
        end
    end

    assign out_o = out_reg;

endmodule // rsf_notch

// ---- rtl/rsf_pkg.sv ----
// Types shared by the resonance suppression filter modules
package rsf_pkg;

    typedef struct packed {
        logic               valid;
        logic signed [15:0] data;
    } rsf_sample_t;

    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] atten;
    } rsf_notch_cfg_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] freq;
        logic [15:0] depth;
    } rsf_detect_t;

    typedef enum logic [1:0] {
        RSF_AUTO_OFF  = 2'b00,
        RSF_AUTO_ONCE = 2'b01,
        RSF_AUTO_CONT = 2'b10
    } rsf_auto_mode_t;

    function automatic logic signed [15:0] rsf_sat16(input logic signed [47:0] v);
        if (v > 48'sh0000_0000_7FFF)
            rsf_sat16 = 16'sh7FFF;
        else if (v < -48'sh0000_0000_8000)
            rsf_sat16 = -16'sh8000;
        else
            rsf_sat16 = v[15:0];
    endfunction

endpackage

// ---- rtl/rsf_top.sv ----
// Resonance suppression filter: parameter store, auto search and filter chain
//
// Summary of operation
// - Third notch attenuation zero bypasses third notch, frequency ignored.
// - Low-pass time constant in 0.1 ms steps, 0 to 1000 accepted.
// - Low-pass constant resets to 2 on low-power models, else 5.
// - Low-pass constant zero passes samples through unchanged.
// - Auto modes 1/2 search and store found notch 2/3 frequency and depth.
// - Mode 1 returns to 0 once stable for about 20 minutes.
// - Mode 2 searches forever and never clears itself.
// - Write 1 anytime, or 2 from 0, clears notch 2/3 and starts.
// - Write 0 while searching keeps notch settings and stops search.
// - Write 2 while searching keeps settings and continues without interruption.
// - Attenuation zero means nothing found; frequency reads 0, since search start clears it.
// - Attenuation accepted only from 0 to 32 dB.
// - First notch acts only between 50 Hz and 1000 Hz.
// - Larger low-pass constant lowers cutoff monotonically.
// - Third notch frequency zero disables third notch.
// - Third notch attenuation 16-bit, range 0 to 32, resets 0.
`timescale 1ns/1ns
`include "rsf_defines.svh"
module rsf_top
    import rsf_pkg::*;
#(
    parameter logic [63:0] STABLE_CYCLES = `RSF_STABLE_CYCLES
)
(
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic         low_power_model_i,
    input  wire logic [15:0]  param_addr_i,
    input  wire logic         param_wr_i,
    input  wire logic [15:0]  param_wdata_i,
    input  wire logic         param_rd_i,
    output logic      [15:0]  param_rdata_o,
    output logic              param_rvalid_o,
    output logic              param_wr_reject_o,
    input  rsf_detect_t       detect_i,
    input  rsf_sample_t       cmd_i,
    output rsf_sample_t       cmd_o,
    output logic              auto_busy_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    rsf_notch_cfg_t  n1_reg, n1_next;
    rsf_notch_cfg_t  n2_reg, n2_next;
    rsf_notch_cfg_t  n3_reg, n3_next;
    logic [15:0]     lp_tc_reg, lp_tc_next;
    rsf_auto_mode_t  mode_reg, mode_next;
    logic [63:0]     stable_reg, stable_next;
    logic [15:0]     rdata_reg, rdata_next;
    logic            rvalid_reg, rvalid_next;
    logic            reject_reg, reject_next;
    logic            strap_meta_reg, strap_sync_reg;
    logic [1:0]      init_cnt_reg, init_cnt_next;
    logic            init_done;
    logic            wr_ok;
    logic            freq_ok;
    logic            att_ok;
    logic            host_wr;
    logic [15:0]     det_depth;
    logic            n1_en, n2_en, n3_en;
    rsf_sample_t     lp_out, n1_out, n2_out;

    assign init_done = (init_cnt_reg == `RSF_STRAP_WAIT);
    assign host_wr   = param_wr_i && init_done;
    assign freq_ok   = (param_wdata_i == 16'h0000) ||
                       ((param_wdata_i >= `RSF_FREQ_MIN) && (param_wdata_i <= `RSF_FREQ_MAX));
    assign att_ok    = (param_wdata_i <= `RSF_ATT_MAX);
    assign det_depth = (detect_i.depth > `RSF_ATT_MAX) ? `RSF_ATT_MAX : detect_i.depth;

    // ****************************************************************
    // Model strap synchroniser
    // ****************************************************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            strap_meta_reg <= 1'b0;
            strap_sync_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            strap_meta_reg <= low_power_model_i;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // ****************************************************************
    // Write acceptance check
    // ****************************************************************
    always_comb
    begin
        case (param_addr_i)
            `RSF_ADDR_N1_FREQ, `RSF_ADDR_N2_FREQ, `RSF_ADDR_N3_FREQ: wr_ok = freq_ok;
            `RSF_ADDR_N1_ATT, `RSF_ADDR_N2_ATT, `RSF_ADDR_N3_ATT:    wr_ok = att_ok;
            `RSF_ADDR_LP_TC: wr_ok = (param_wdata_i <= `RSF_LP_TC_MAX);
            `RSF_ADDR_AUTO:  wr_ok = (param_wdata_i <= 16'h0002);
            default:         wr_ok = 1'b0;
        endcase
    end

    // ****************************************************************
    // Parameter store and auto search
    // ****************************************************************
    always_comb
    begin
        n1_next       = n1_reg;
        n2_next       = n2_reg;
        n3_next       = n3_reg;
        lp_tc_next    = lp_tc_reg;
        mode_next     = mode_reg;
        stable_next   = stable_reg;
        init_cnt_next = init_cnt_reg;
        reject_next   = host_wr && !wr_ok;

        // Load the model-dependent default once the strap has settled
        if (!init_done)
        begin
            init_cnt_next = init_cnt_reg + 2'h1;
            if (init_cnt_reg == 2'h2)
                lp_tc_next = strap_sync_reg ? `RSF_LP_TC_RST_LOW
                                            : `RSF_LP_TC_RST_HIGH;
        end

        // Search: results go to notch 2 first, then notch 3
        case (mode_reg)
            RSF_AUTO_ONCE, RSF_AUTO_CONT:
            begin
                if (detect_i.valid && det_depth != 16'h0000)
                begin
                    stable_next = 64'h0000_0000_0000_0000;
                    if (n2_reg.atten == 16'h0000)
                    begin
                        n2_next.freq  = detect_i.freq;
                        n2_next.atten = det_depth;
                    end
                    else
                    begin
                        n3_next.freq  = detect_i.freq;
                        n3_next.atten = det_depth;
                    end
                end
                else if (mode_reg == RSF_AUTO_ONCE)
                begin
                    if (stable_reg >= STABLE_CYCLES - 64'h0000_0000_0000_0001)
                    begin
                        mode_next   = RSF_AUTO_OFF;
                        stable_next = 64'h0000_0000_0000_0000;
                    end
                    else
                        stable_next = stable_reg + 64'h0000_0000_0000_0001;
                end
                // Continuous mode holds its setting indefinitely
            end
            default:
                stable_next = 64'h0000_0000_0000_0000;
        endcase

        // Host writes take effect over the search result of the same cycle
        if (host_wr && wr_ok)
        begin
            case (param_addr_i)
                `RSF_ADDR_N1_FREQ: n1_next.freq  = param_wdata_i;
                `RSF_ADDR_N1_ATT:  n1_next.atten = param_wdata_i;
                `RSF_ADDR_N2_FREQ: n2_next.freq  = param_wdata_i;
                `RSF_ADDR_N2_ATT:  n2_next.atten = param_wdata_i;
                `RSF_ADDR_N3_FREQ: n3_next.freq  = param_wdata_i;
                `RSF_ADDR_N3_ATT:  n3_next.atten = param_wdata_i;
                `RSF_ADDR_LP_TC:   lp_tc_next    = param_wdata_i;
                `RSF_ADDR_AUTO:
                begin
                    if (param_wdata_i == 16'h0000)
                    begin
                        mode_next = RSF_AUTO_OFF;
                    end
                    else if (param_wdata_i == 16'h0001 || mode_reg == RSF_AUTO_OFF)
                    begin
                        n2_next     = '0;
                        n3_next     = '0;
                        stable_next = 64'h0000_0000_0000_0000;
                        mode_next   = (param_wdata_i == 16'h0001) ? RSF_AUTO_ONCE
                                                                  : RSF_AUTO_CONT;
                    end
                    else
                    begin
                        mode_next = RSF_AUTO_CONT;
                    end
                end
                default:
                begin
                    mode_next = mode_next;
                end
            endcase
        end
    end

    // ****************************************************************
    // Readback
    // ****************************************************************
    always_comb
    begin
        rvalid_next = param_rd_i;
        rdata_next  = rdata_reg;
        if (param_rd_i)
        begin
            case (param_addr_i)
                `RSF_ADDR_N1_FREQ: rdata_next = n1_reg.freq;
                `RSF_ADDR_N1_ATT:  rdata_next = n1_reg.atten;
                `RSF_ADDR_N2_FREQ: rdata_next = n2_reg.freq;
                `RSF_ADDR_N2_ATT:  rdata_next = n2_reg.atten;
                `RSF_ADDR_N3_FREQ: rdata_next = n3_reg.freq;
                `RSF_ADDR_N3_ATT:  rdata_next = n3_reg.atten;
                `RSF_ADDR_LP_TC:   rdata_next = lp_tc_reg;
                `RSF_ADDR_AUTO:    rdata_next = {14'h0000, mode_reg};
                default:           rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            n1_reg       <= '{freq: `RSF_FREQ_RST, atten: `RSF_ATT_RST};
            n2_reg       <= '{freq: `RSF_FREQ_RST, atten: `RSF_ATT_RST};
            n3_reg       <= '{freq: `RSF_FREQ_RST, atten: `RSF_ATT_RST};
            lp_tc_reg    <= `RSF_LP_TC_RST_HIGH;
            mode_reg     <= RSF_AUTO_OFF;
            stable_reg   <= 64'h0000_0000_0000_0000;
            init_cnt_reg <= 2'h0;
            rdata_reg    <= 16'h0000;
            rvalid_reg   <= 1'b0;
            reject_reg   <= 1'b0;
        end
        else if (ce_i)
        begin
            n1_reg       <= n1_next;
            n2_reg       <= n2_next;
            n3_reg       <= n3_next;
            lp_tc_reg    <= lp_tc_next;
            mode_reg     <= mode_next;
            stable_reg   <= stable_next;
            init_cnt_reg <= init_cnt_next;
            rdata_reg    <= rdata_next;
            rvalid_reg   <= rvalid_next;
            reject_reg   <= reject_next;
        end
    end

    // ****************************************************************
    // Filter chain: low-pass, then three notches in series
    // ****************************************************************
    assign n1_en = (n1_reg.atten != 16'h0000) && (n1_reg.freq >= `RSF_FREQ_MIN) &&
                   (n1_reg.freq <= `RSF_N1_FREQ_MAX);
    assign n2_en = (n2_reg.atten != 16'h0000) && (n2_reg.freq != 16'h0000);
    assign n3_en = (n3_reg.atten != 16'h0000)
                && (n3_reg.freq != 16'h0000);

    rsf_lowpass u_lowpass (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .tc_i      (lp_tc_reg),
        .in_i      (cmd_i),
        .out_o     (lp_out)
    );

    rsf_notch u_notch1 (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .en_i      (n1_en),
        .cfg_i     (n1_reg),
        .in_i      (lp_out),
        .out_o     (n1_out)
    );

    rsf_notch u_notch2 (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .en_i      (n2_en),
        .cfg_i     (n2_reg),
        .in_i      (n1_out),
        .out_o     (n2_out)
    );

    rsf_notch u_notch3 (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .en_i      (n3_en),
        .cfg_i     (n3_reg),
        .in_i      (n2_out),
        .out_o     (cmd_o)
    );

    assign param_rdata_o     = rdata_reg;
    assign param_rvalid_o    = rvalid_reg;
    assign param_wr_reject_o = reject_reg;
    assign auto_busy_o       = (mode_reg != RSF_AUTO_OFF);

endmodule // rsf_top

// ---- tb/rsf_assertions.sv ----
// Port checker of the resonance suppression filter
`timescale 1ns/1ns
`include "rsf_defines.svh"
module rsf_assertions
    import rsf_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic [15:0] param_addr_i,
    input  wire logic        param_wr_i,
    input  wire logic [15:0] param_wdata_i,
    input  wire logic        param_rd_i,
    input  wire logic [15:0] param_rdata_o,
    input  wire logic        param_rvalid_o,
    input  wire logic        param_wr_reject_o,
    input  rsf_sample_t      cmd_i,
    input  rsf_sample_t      cmd_o
);
// ****************************************************************
// Assertions
// ****************************************************************
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!rst_n_i);
sequence s_rd; param_rd_i && ce_i; endsequence
sequence s_wr; param_wr_i && ce_i; endsequence
sequence s_tc; param_wr_i && ce_i && param_addr_i == `RSF_ADDR_LP_TC; endsequence
rd_answer_a: assert property (s_rd |=> param_rvalid_o)
    else $error("read not answered");
rd_hold_a: assert property (!param_rvalid_o |-> $stable(param_rdata_o))
    else $error("read data moved");
tc_big_a: assert property (s_tc ##0 param_wdata_i > `RSF_LP_TC_MAX |=> param_wr_reject_o)
    else $error("large constant kept");
tc_ok_a: assert property (s_tc ##0 param_wdata_i <= `RSF_LP_TC_MAX |=> !param_wr_reject_o)
    else $error("legal constant refused");
odd_wr_a: assert property (s_wr ##0 param_addr_i[0] |=> param_wr_reject_o)
    else $error("odd address write kept");
idle_rej_a: assert property (!param_wr_i |=> !param_wr_reject_o)
    else $error("refusal without write");
att_big_a: assert property (s_wr ##0 param_addr_i == `RSF_ADDR_N3_ATT
    && param_wdata_i > `RSF_ATT_MAX |=> param_wr_reject_o)
    else $error("deep attenuation kept");
chain_lat_a: assert property (cmd_i.valid && ce_i |-> ##4 cmd_o.valid)
    else $error("sample latency wrong");
endmodule // rsf_assertions
bind rsf_top rsf_assertions rsf_assertions_inst (.sys_clk_i, .rst_n_i, .ce_i,
    .param_addr_i, .param_wr_i, .param_wdata_i, .param_rd_i, .param_rdata_o,
    .param_rvalid_o, .param_wr_reject_o, .cmd_i, .cmd_o);

// ---- tb/rsf_partner.sv ----
// Command path model feeding samples and resonance reports
`timescale 1ns/1ns
module rsf_partner
    import rsf_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        send_i,
    input  wire logic [15:0] val_i,
    input  wire logic        det_i,
    input  wire logic [15:0] freq_i,
    input  wire logic [15:0] depth_i,
    output rsf_sample_t      smp_o,
    output rsf_detect_t      det_o
);
initial smp_o = '0;
initial det_o = '0;
always @(posedge sys_clk_i)
begin
    smp_o.valid <= send_i;
    // Data toggles between samples
    smp_o.data  <= send_i ? val_i : ~smp_o.data;
    det_o       <= det_i ? {1'b1, freq_i, depth_i} : {1'b0, ~det_o.freq, ~det_o.depth};
end
endmodule // rsf_partner

// ---- tb/rsf_tb_top.sv ----
// Self-checking bench of the resonance suppression filter
`timescale 1ns/1ns
`include "rsf_defines.svh"
module rsf_tb_top
    import rsf_pkg::*;
;
logic        sys_clk_i = 0, rst_n_i = 0, low_power_model_i = 0, param_wr_i = 0, ce = 1;
logic        param_rd_i = 0, send = 0, det = 0, param_rvalid_o, param_wr_reject_o, auto_busy_o;
logic [15:0] param_addr_i = 0, param_wdata_i = 0, val = 0, df = 0, dd = 0, param_rdata_o;
rsf_sample_t cmd_i, cmd_o;
rsf_detect_t detect_i;
int          err_count = 0, checked = 0, cyc = 0;
logic [15:0] ra [8] = '{`RSF_ADDR_N1_FREQ, `RSF_ADDR_N1_ATT, `RSF_ADDR_LP_TC, `RSF_ADDR_N2_FREQ,
    `RSF_ADDR_N2_ATT, `RSF_ADDR_N3_FREQ, `RSF_ADDR_N3_ATT, `RSF_ADDR_AUTO};
logic [15:0] rv [8] = '{16'h03E8, 16'h0000, 16'h0005, 16'h03E8, 16'h0000, 16'h03E8, 16'h0000, 16'h0000};
rsf_top #(.STABLE_CYCLES(64'h0000_0000_0000_0014)) rsf_top_inst (.sys_clk_i, .rst_n_i,
    .ce_i(ce), .low_power_model_i, .param_addr_i, .param_wr_i, .param_wdata_i,
    .param_rd_i, .param_rdata_o, .param_rvalid_o, .param_wr_reject_o, .detect_i,
    .cmd_i, .cmd_o, .auto_busy_o);
rsf_partner rsf_partner_inst (.sys_clk_i, .send_i(send), .val_i(val), .det_i(det),
    .freq_i(df), .depth_i(dd), .smp_o(cmd_i), .det_o(detect_i));
// ****************************************************************
// Tasks
// ****************************************************************
task automatic tally_and_finish;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
        err_count++;
        $display("[ERR] %0t got %h want %h", $time, g, e);
    end
endtask
task automatic chk_b(input logic g, input logic e);
    chk_w({15'h0000, g}, {15'h0000, e});
endtask
task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic r);
    @(posedge sys_clk_i);
    param_addr_i <= a;
    param_wdata_i <= d;
    param_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    param_wr_i <= 1'b0;
    #1 chk_b(param_wr_reject_o, r);
endtask
task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    param_addr_i <= a;
    param_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    param_rd_i <= 1'b0;
    #1 chk_b(param_rvalid_o, 1'b1);
    chk_w(param_rdata_o, e);
endtask
task automatic smp(input logic [15:0] v);
    @(posedge sys_clk_i);
    send <= 1'b1;
    val <= v;
    @(posedge sys_clk_i);
    send <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1 chk_b(cmd_o.valid, 1'b1);
    chk_w(cmd_o.data, v);
endtask
task automatic dt(input logic [15:0] f, input logic [15:0] d);
    @(posedge sys_clk_i);
    det <= 1'b1;
    df <= f;
    dd <= d;
    @(posedge sys_clk_i);
    det <= 1'b0;
    @(posedge sys_clk_i);
endtask
task automatic rst(input logic s);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    low_power_model_i <= s;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
endtask
// ****************************************************************
// Sequence
// ****************************************************************
initial forever #2 sys_clk_i = ~sys_clk_i;
always @(posedge sys_clk_i)
begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
        err_count++;
        tally_and_finish;
    end
end
initial
begin
    rst(1'b0);
    foreach (ra[i]) rd(ra[i], rv[i]);
    rd(16'h0233, 16'h0000);
    wr(`RSF_ADDR_LP_TC, 16'h000F, 1'b0);
    wr(`RSF_ADDR_LP_TC, 16'h03E9, 1'b1);
    rd(`RSF_ADDR_LP_TC, 16'h000F);
    wr(16'h0233, 16'h0001, 1'b1);
    wr(`RSF_ADDR_N3_ATT, 16'h0021, 1'b1);
    wr(`RSF_ADDR_N3_ATT, 16'h0020, 1'b0);
    wr(`RSF_ADDR_N3_ATT, 16'h0000, 1'b0);
    wr(`RSF_ADDR_LP_TC, 16'h0000, 1'b0);
    wr(`RSF_ADDR_N3_FREQ, 16'h01F4, 1'b0);
    smp(16'h1234);
    wr(`RSF_ADDR_AUTO, 16'h0001, 1'b0);
    chk_b(auto_busy_o, 1'b1);
    rd(`RSF_ADDR_N2_FREQ, 16'h0000);
    rd(`RSF_ADDR_N3_FREQ, 16'h0000);
    dt(16'h012C, 16'h0028);
    rd(`RSF_ADDR_N2_FREQ, 16'h012C);
    rd(`RSF_ADDR_N2_ATT, 16'h0020);
    dt(16'h01F4, 16'h000A);
    rd(`RSF_ADDR_N3_ATT, 16'h000A);
    wr(`RSF_ADDR_AUTO, 16'h0002, 1'b0);
    rd(`RSF_ADDR_N2_FREQ, 16'h012C);
    repeat (40) @(posedge sys_clk_i);
    rd(`RSF_ADDR_AUTO, 16'h0002);
    wr(`RSF_ADDR_AUTO, 16'h0000, 1'b0);
    rd(`RSF_ADDR_N3_FREQ, 16'h01F4);
    wr(`RSF_ADDR_AUTO, 16'h0003, 1'b1);
    wr(`RSF_ADDR_AUTO, 16'h0001, 1'b0);
    repeat (30) @(posedge sys_clk_i);
    rd(`RSF_ADDR_AUTO, 16'h0000);
    chk_b(auto_busy_o, 1'b0);
    rd(`RSF_ADDR_N2_ATT, 16'h0000);
    @(posedge sys_clk_i) ce <= 1'b0;
    wr(`RSF_ADDR_LP_TC, 16'h0064, 1'b0);
    @(posedge sys_clk_i) ce <= 1'b1;
    rd(`RSF_ADDR_LP_TC, 16'h0000);
    rst(1'b1);
    rd(`RSF_ADDR_LP_TC, 16'h0002);
    tally_and_finish;
end
endmodule // rsf_tb_top
